/* File: src/rct_top.v */
// reload/capture timer pair with shared clock select register
//
// Overview of operation
// (R1) split clear: one 16-bit counter, one step per selected clock edge.
// (R2) 16-bit wrap from FFFF loads reload pair and sets high flag.
// (R3) interrupt on each 16-bit overflow when enabled.
// (R4) with low interrupt enable, also interrupt on low byte rollover.
// (R5) split set: two 8-bit halves, each reloading on its own overflow.
// (R6) low half reloads from low reload byte.
// (R7) high half reloads from high reload byte.
// (R8) in split, run bit gates high half only; low always counts.
// (R9) split: high rollover sets high flag, low rollover sets low flag.
// (R10) split: interrupt on high overflow, either half with low enable.
// (R11) flags never cleared by hardware; software clears and inspects both.
// (R12) capture enable makes counter run freely over full 16 bits.
// (R13) software keeps split clear while capture is on.
// (R14) capture input falling edge copies count to reload, sets high flag.
// (R15) capture input chosen per timer from two sources.
// (R16) bits 7/6 pick second timer high/low clock: external or system.
// (R17) bits 5/4 pick first timer high/low clock: external or system.
// (R18) bit 3 picks legacy timer one clock; ignored in counter mode.
// (R19) clock select register resets to zero.
// (R20) 16-bit modes use the low half clock for the whole counter.
// (R21) external clock choices: system_clock/12, comparator, oscillator/8.
// (R22) prescale field picks system_clock/12, /4, /48 or ext oscillator/8.
// (R23) async clock and capture inputs synchronised, edge counted once.
// (R24) hardware flag set wins over a same-cycle software write.
`timescale 1ns/1ps
module rct_top (
	// clock and reset
	input  wire       core_clk_i,
	input  wire       resetn_i,
	// special function register port
	input  wire [7:0] sfr_addr_i,
	input  wire       sfr_wr_i,
	input  wire [7:0] sfr_wdata_i,
	output reg  [7:0] sfr_rdata_o,
	// asynchronous source pins
	input  wire       cmp0_i,
	input  wire       cmp1_i,
	input  wire       slow_osc_i,
	input  wire       ext_osc_i,
	// capture source selects, one per timer
	input  wire [1:0] capture_select_i,
	// interrupt enables kept outside the block
	input  wire [1:0] timer_int_en_i,
	// legacy timer one mode and its pin tick
	input  wire       legacy_one_counter_mode_i,
	input  wire       legacy_one_pin_tick_i,
	// interrupt requests, one per timer
	output reg  [1:0] timer_irq_o,
	// legacy timer clock ticks
	output reg        legacy_zero_tick_o,
	output reg        legacy_one_tick_o
);
`include "rct_consts.vh"

	// ************************************
	// input synchronisers
	// ************************************

	// pin order: cmp0, cmp1, slow osc, ext osc
	wire [3:0] pin_raw = {ext_osc_i, slow_osc_i, cmp1_i, cmp0_i};
	reg  [3:0] sync1;
	reg  [3:0] sync2;
	reg  [3:0] sync3;
	reg  [3:0] pin_lvl;
	reg  [3:0] pin_lvl_d;
	wire [3:0] pin_rise = pin_lvl & ~pin_lvl_d;
	wire [3:0] pin_fall = ~pin_lvl & pin_lvl_d;

	genvar gp;
	generate
		for (gp = 0; gp < 4; gp = gp + 1) begin : g_pin
			// (R23) three stages, accept level once stages two and three agree
			always @(posedge core_clk_i) begin
				if (!resetn_i) begin
					sync1[gp]     <= 1'b0;
					sync2[gp]     <= 1'b0;
					sync3[gp]     <= 1'b0;
					pin_lvl[gp]   <= 1'b0;
					pin_lvl_d[gp] <= 1'b0;
				end else begin
					sync1[gp]     <= pin_raw[gp];
					sync2[gp]     <= sync1[gp];
					sync3[gp]     <= sync2[gp];
					pin_lvl_d[gp] <= pin_lvl[gp];
					if (sync2[gp] == sync3[gp]) begin
						pin_lvl[gp] <= sync3[gp];
					end
				end
			end
		end
	endgenerate

	// ************************************
	// oscillator dividers
	// ************************************

	// divide by 8 counts rising edges of the synchronised oscillator;
	// an oscillator near the system clock rate loses edges here
	reg  [2:0] slow_div;
	reg  [2:0] ext_div;
	wire       slow_div8_tick = pin_rise[2] && (slow_div == `RCT_OSC_DIV_LAST);
	wire       ext_div8_tick  = pin_rise[3] && (ext_div == `RCT_OSC_DIV_LAST);

	// the divided clocks fall when their counters wrap
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			slow_div <= 3'h0;
			ext_div  <= 3'h0;
		end else begin
			if (pin_rise[2]) begin
				slow_div <= slow_div + 3'h1;
			end
			if (pin_rise[3]) begin
				ext_div <= ext_div + 3'h1;
			end
		end
	end

	// ************************************
	// system clock prescaler
	// ************************************

	// one modulo-48 counter serves all three ratios
	reg  [5:0] pre_cnt;
	wire       div48_tick = (pre_cnt == `RCT_PRE_MOD);
	wire       div4_tick  = ((pre_cnt & `RCT_PRE_DIV4_MASK) == `RCT_PRE_DIV4_MASK);
	wire       div12_tick = (pre_cnt == `RCT_PRE_DIV12_A) || (pre_cnt == `RCT_PRE_DIV12_B) ||
	                        (pre_cnt == `RCT_PRE_DIV12_C) || div48_tick;

	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pre_cnt <= 6'h00;
		end else if (div48_tick) begin
			pre_cnt <= 6'h00;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
		end
	end

	// ************************************
	// clock select register
	// ************************************

	reg  [7:0] timer_clock_select;
	wire       wr_clksel = sfr_wr_i && (sfr_addr_i == `RCT_ADDR_CLKSEL);

	// (R19) clears to all zeros
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			timer_clock_select <= `RCT_CLKSEL_RESET;
		end else if (wr_clksel) begin
			timer_clock_select <= sfr_wdata_i;
		end
	end

	// ************************************
	// legacy timer clocks
	// ************************************

	reg  presc_tick;
	wire [1:0] legacy_prescale_field =
		timer_clock_select[`RCT_CS_PRESC_MSB:`RCT_CS_PRESC_LSB];

	// (R22) prescale field choice
	always @* begin
		case (legacy_prescale_field)
			2'h0:    presc_tick = div12_tick;
			2'h1:    presc_tick = div4_tick;
			2'h2:    presc_tick = div48_tick;
			default: presc_tick = ext_div8_tick;
		endcase
	end

	// legacy ticks are registered, one cycle behind their source
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			legacy_zero_tick_o <= 1'b0;
			legacy_one_tick_o  <= 1'b0;
		end else begin
			legacy_zero_tick_o <= timer_clock_select[`RCT_CS_LEG_ZERO] ? 1'b1 : presc_tick;
			// (R18) counter mode overrides the clock select bit
			if (legacy_one_counter_mode_i) begin
				legacy_one_tick_o <= legacy_one_pin_tick_i;
			end else begin
				legacy_one_tick_o <= timer_clock_select[`RCT_CS_LEG_ONE] ? 1'b1 : presc_tick;
			end
		end
	end

	// ************************************
	// per-timer sources
	// ************************************

	wire [7:0]  ctrl   [0:1];
	wire [15:0] reload [0:1];
	wire [15:0] count  [0:1];
	wire [7:0]  addr_ctrl [0:1];
	wire [7:0]  addr_rll  [0:1];
	wire [7:0]  addr_rlh  [0:1];
	wire [7:0]  addr_cntl [0:1];
	wire [7:0]  addr_cnth [0:1];
	reg  [1:0]  ext_tick;
	reg  [1:0]  cap_evt;
	wire [1:0]  tick_low;
	wire [1:0]  tick_high;

	assign addr_ctrl[0] = `RCT_ADDR_T0_CTRL;
	assign addr_rll[0]  = `RCT_ADDR_T0_RLL;
	assign addr_rlh[0]  = `RCT_ADDR_T0_RLH;
	assign addr_cntl[0] = `RCT_ADDR_T0_CNTL;
	assign addr_cnth[0] = `RCT_ADDR_T0_CNTH;
	assign addr_ctrl[1] = `RCT_ADDR_T1_CTRL;
	assign addr_rll[1]  = `RCT_ADDR_T1_RLL;
	assign addr_rlh[1]  = `RCT_ADDR_T1_RLH;
	assign addr_cntl[1] = `RCT_ADDR_T1_CNTL;
	assign addr_cnth[1] = `RCT_ADDR_T1_CNTH;

	// (R21) external clock choice per timer; code 3 gives no tick
	always @* begin
		case (ctrl[0][`RCT_CT_XSEL_MSB:`RCT_CT_XSEL_LSB])
			2'h0:    ext_tick[0] = div12_tick;
			2'h1:    ext_tick[0] = pin_rise[0];
			2'h2:    ext_tick[0] = slow_div8_tick;
			default: ext_tick[0] = 1'b0;
		endcase
		case (ctrl[1][`RCT_CT_XSEL_MSB:`RCT_CT_XSEL_LSB])
			2'h0:    ext_tick[1] = div12_tick;
			2'h1:    ext_tick[1] = ext_div8_tick;
			2'h2:    ext_tick[1] = pin_rise[1];
			default: ext_tick[1] = 1'b0;
		endcase
	end

	// (R15) capture source: select 1 takes the first listed source
	always @* begin
		cap_evt[0] = capture_select_i[0] ? pin_fall[0] : slow_div8_tick;
		cap_evt[1] = capture_select_i[1] ? ext_div8_tick : pin_fall[1];
	end

	// (R17) first timer half clocks
	assign tick_low[0]  = timer_clock_select[`RCT_CS_T0_LOW] ? 1'b1 : ext_tick[0];
	assign tick_high[0] = timer_clock_select[`RCT_CS_T0_HIGH] ? 1'b1 : ext_tick[0];
	// (R16) second timer half clocks
	assign tick_low[1]  = timer_clock_select[`RCT_CS_T1_LOW] ? 1'b1 : ext_tick[1];
	assign tick_high[1] = timer_clock_select[`RCT_CS_T1_HIGH] ? 1'b1 : ext_tick[1];

	// ************************************
	// timer instances
	// ************************************

	genvar gt;
	generate
		for (gt = 0; gt < 2; gt = gt + 1) begin : g_tmr
			// (R5) (R20) the core takes the low tick for 16-bit modes
			rct_timer u_timer (
				.core_clk_i  (core_clk_i),
				.resetn_i    (resetn_i),
				.wr_ctrl_i   (sfr_wr_i && (sfr_addr_i == addr_ctrl[gt])),
				.wr_rll_i    (sfr_wr_i && (sfr_addr_i == addr_rll[gt])),
				.wr_rlh_i    (sfr_wr_i && (sfr_addr_i == addr_rlh[gt])),
				.wr_cntl_i   (sfr_wr_i && (sfr_addr_i == addr_cntl[gt])),
				.wr_cnth_i   (sfr_wr_i && (sfr_addr_i == addr_cnth[gt])),
				.wdata_i     (sfr_wdata_i),
				.tick_low_i  (tick_low[gt]),
				.tick_high_i (tick_high[gt]),
				.cap_evt_i   (cap_evt[gt]),
				.ctrl_o      (ctrl[gt]),
				.reload_o    (reload[gt]),
				.count_o     (count[gt])
			);

			// (R3) (R4) (R10) request follows the sticky flags
			always @(posedge core_clk_i) begin
				if (!resetn_i) begin
					timer_irq_o[gt] <= 1'b0;
				end else begin
					timer_irq_o[gt] <= timer_int_en_i[gt] &&
						(ctrl[gt][`RCT_CT_HFLAG] ||
						(ctrl[gt][`RCT_CT_LIEN] && ctrl[gt][`RCT_CT_LFLAG]));
				end
			end
		end
	endgenerate

	// ************************************
	// register read port
	// ************************************

	reg [7:0] next_rdata;

	// unmapped addresses read as zero
	always @* begin
		case (sfr_addr_i)
			`RCT_ADDR_CLKSEL:  next_rdata = timer_clock_select;
			`RCT_ADDR_T0_CTRL: next_rdata = ctrl[0];
			`RCT_ADDR_T0_RLL:  next_rdata = reload[0][7:0];
			`RCT_ADDR_T0_RLH:  next_rdata = reload[0][15:8];
			`RCT_ADDR_T0_CNTL: next_rdata = count[0][7:0];
			`RCT_ADDR_T0_CNTH: next_rdata = count[0][15:8];
			`RCT_ADDR_T1_CTRL: next_rdata = ctrl[1];
			`RCT_ADDR_T1_RLL:  next_rdata = reload[1][7:0];
			`RCT_ADDR_T1_RLH:  next_rdata = reload[1][15:8];
			`RCT_ADDR_T1_CNTL: next_rdata = count[1][7:0];
			`RCT_ADDR_T1_CNTH: next_rdata = count[1][15:8];
			default:           next_rdata = 8'h00;
		endcase
	end

	// read data registered: valid one cycle after the address
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= next_rdata;
		end
	end

endmodule

/* File: common/rct_consts.vh */
// constants for the reload/capture timer pair
`ifndef RCT_CONSTS_VH
`define RCT_CONSTS_VH
// ************************************
// register addresses
// ************************************
`define RCT_ADDR_CLKSEL     8'h8E
`define RCT_ADDR_T0_CTRL    8'hC8
`define RCT_ADDR_T0_RLL     8'hCA
`define RCT_ADDR_T0_RLH     8'hCB
`define RCT_ADDR_T0_CNTL    8'hCC
`define RCT_ADDR_T0_CNTH    8'hCD
`define RCT_ADDR_T1_CTRL    8'h91
`define RCT_ADDR_T1_RLL     8'h92
`define RCT_ADDR_T1_RLH     8'h93
`define RCT_ADDR_T1_CNTL    8'h94
`define RCT_ADDR_T1_CNTH    8'h95
// ************************************
// clock select fields
// ************************************
`define RCT_CS_T1_HIGH      7
`define RCT_CS_T1_LOW       6
`define RCT_CS_T0_HIGH      5
`define RCT_CS_T0_LOW       4
`define RCT_CS_LEG_ONE      3
`define RCT_CS_LEG_ZERO     2
`define RCT_CS_PRESC_MSB    1
`define RCT_CS_PRESC_LSB    0
`define RCT_CLKSEL_RESET    8'h00
// ************************************
// timer control fields
// ************************************
`define RCT_CT_HFLAG        7
`define RCT_CT_LFLAG        6
`define RCT_CT_LIEN         5
`define RCT_CT_CAPEN        4
`define RCT_CT_SPLIT        3
`define RCT_CT_RUN          2
`define RCT_CT_XSEL_MSB     1
`define RCT_CT_XSEL_LSB     0
`define RCT_CTRL_RESET      8'h00
`define RCT_RELOAD_RESET    16'h0000
`define RCT_COUNT_RESET     16'h0000
// ************************************
// prescaler counts
// ************************************
`define RCT_PRE_MOD         6'h2F
`define RCT_PRE_DIV4_MASK   6'h03
`define RCT_PRE_DIV12_A     6'h0B
`define RCT_PRE_DIV12_B     6'h17
`define RCT_PRE_DIV12_C     6'h23
`define RCT_OSC_DIV_LAST    3'h7
`endif

/* File: src/rct_timer.v */
// one 16-bit reload/capture timer with split mode
`timescale 1ns/1ps
module rct_timer (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        resetn_i,
	// register writes
	input  wire        wr_ctrl_i,
	input  wire        wr_rll_i,
	input  wire        wr_rlh_i,
	input  wire        wr_cntl_i,
	input  wire        wr_cnth_i,
	input  wire [7:0]  wdata_i,
	// count ticks and capture event
	input  wire        tick_low_i,
	input  wire        tick_high_i,
	input  wire        cap_evt_i,
	// register state
	output reg  [7:0]  ctrl_o,
	output reg  [15:0] reload_o,
	output reg  [15:0] count_o
);
`include "rct_consts.vh"
	wire       split    = ctrl_o[`RCT_CT_SPLIT];
	wire       run      = ctrl_o[`RCT_CT_RUN];
	wire       cap_en   = ctrl_o[`RCT_CT_CAPEN];
	wire       low_full = (count_o[7:0] == 8'hFF);
	wire       hi_full  = (count_o[15:8] == 8'hFF);
	// (R1) 16-bit counting
	wire       tick16   = !split && run && tick_low_i;
	// (R8) low half free runs, high gated
	wire       tick_lo8 = split && tick_low_i;
	wire       tick_hi8 = split && run && tick_high_i;
	wire       wrap16   = tick16 && low_full && hi_full;
	// (R9) half overflow events
	wire       set_h    = (tick_hi8 && hi_full) || (wrap16 && !cap_en) || (cap_en && cap_evt_i);
	wire       set_l    = (tick_lo8 || tick16) && low_full;
	reg  [7:0] next_ctrl;
	// control register; hardware set wins
	always @* begin
		next_ctrl = wr_ctrl_i ? wdata_i : ctrl_o;
		// (R24) set beats clear
		if (set_h) begin
			next_ctrl[`RCT_CT_HFLAG] = 1'b1;
		end
		if (set_l) begin
			next_ctrl[`RCT_CT_LFLAG] = 1'b1;
		end
	end
	// (R11) flags cleared only by software write
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ctrl_o <= `RCT_CTRL_RESET;
		end else begin
			ctrl_o <= next_ctrl;
		end
	end
	// reload pair; capture beats a software write
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			reload_o <= `RCT_RELOAD_RESET;
		end else if (cap_en && cap_evt_i) begin
			// (R14) capture current count
			reload_o <= count_o;
		end else begin
			if (wr_rll_i) begin
				reload_o[7:0] <= wdata_i;
			end
			if (wr_rlh_i) begin
				reload_o[15:8] <= wdata_i;
			end
		end
	end
	// counter; software write of a byte wins that byte
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			count_o <= `RCT_COUNT_RESET;
		end else begin
			if (wr_cntl_i) begin
				count_o[7:0] <= wdata_i;
			end else if (tick_lo8) begin
				// (R6) low half reload
				count_o[7:0] <= low_full ? reload_o[7:0] : count_o[7:0] + 8'h01;
			end else if (tick16) begin
				count_o[7:0] <= (wrap16 && !cap_en) ? reload_o[7:0] : count_o[7:0] + 8'h01;
			end
			if (wr_cnth_i) begin
				count_o[15:8] <= wdata_i;
			end else if (tick_hi8) begin
				// (R7) high half reload
				count_o[15:8] <= hi_full ? reload_o[15:8] : count_o[15:8] + 8'h01;
			end else if (tick16 && low_full) begin
				// (R2) (R12) reload, or free wrap in capture
				count_o[15:8] <= (wrap16 && !cap_en) ? reload_o[15:8] : count_o[15:8] + 8'h01;
			end
		end
	end
endmodule

/* File: testbench/rct_top_chk.sv */
// port assertions for the reload/capture timer pair
`timescale 1ns/1ps
module rct_top_chk (
	// clock, reset and register port
	input wire       core_clk_i,
	input wire       resetn_i,
	input wire [7:0] sfr_addr_i,
	input wire       sfr_wr_i,
	input wire [7:0] sfr_wdata_i,
	input wire [7:0] sfr_rdata_o,
	// legacy and interrupt side
	input wire       legacy_one_counter_mode_i,
	input wire       legacy_one_pin_tick_i,
	input wire [1:0] timer_int_en_i,
	input wire [1:0] timer_irq_o,
	input wire       legacy_zero_tick_o,
	input wire       legacy_one_tick_o
);
	reg [7:0] sel;
	// ****
	// clock select shadow
	// ****
	// shadow follows writes so the checks know the selects
	always @(posedge core_clk_i) begin
		if (!resetn_i)
			sel <= 8'h00;
		else if (sfr_wr_i && sfr_addr_i == 8'h8E)
			sel <= sfr_wdata_i;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	a_reset_quiet: assert property ($rose(resetn_i) |->
		sfr_rdata_o == 8'h00 && timer_irq_o == 2'b00 && !legacy_zero_tick_o)
		else $error("outputs active right after reset");
	a_select_read: assert property (sfr_addr_i == 8'h8E |=>
		sfr_rdata_o == $past(sel)) else $error("clock select readback wrong");
	a_zero_sys_tick: assert property (sel[2] |=> legacy_zero_tick_o)
		else $error("legacy zero tick missing on system clock");
	a_one_sys_tick: assert property (sel[3] && !legacy_one_counter_mode_i |=>
		legacy_one_tick_o) else $error("legacy one tick missing on system clock");
	a_one_pin_path: assert property (legacy_one_counter_mode_i |=>
		legacy_one_tick_o == $past(legacy_one_pin_tick_i))
		else $error("legacy one tick does not follow pin");
	// a select change ends the period check early
	a_div4_period: assert property (legacy_zero_tick_o && sel[2:0] == 3'b001 && $stable(sel)
		|=> (!legacy_zero_tick_o || sel[2:0] != 3'b001) [*3]
		##1 (legacy_zero_tick_o || sel[2:0] != 3'b001)) else $error("divide by 4 period wrong");
	a_irq_gated: assert property (1'b1 |=>
		(timer_irq_o & ~$past(timer_int_en_i)) == 2'b00) else $error("irq without enable");
	a_irq_sticky: assert property (timer_irq_o[0] && timer_int_en_i[0] && !sfr_wr_i
		&& !$past(sfr_wr_i) |=> timer_irq_o[0]) else $error("flag cleared without a write");
	c_div4: cover property (legacy_zero_tick_o && sel[2:0] == 3'b001);
	c_irq: cover property ($rose(timer_irq_o[0]));
	c_pin: cover property (legacy_one_counter_mode_i && legacy_one_pin_tick_i);
endmodule
bind rct_top rct_top_chk u_chk (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
	.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.legacy_one_counter_mode_i(legacy_one_counter_mode_i),
	.legacy_one_pin_tick_i(legacy_one_pin_tick_i), .timer_int_en_i(timer_int_en_i),
	.timer_irq_o(timer_irq_o), .legacy_zero_tick_o(legacy_zero_tick_o),
	.legacy_one_tick_o(legacy_one_tick_o));

/* File: testbench/rct_top_bench.sv */
// self-checking bench for the reload/capture timer pair
`timescale 1ns/1ps
module rct_top_bench;
	reg        core_clk_i = 1'b0;
	reg        resetn_i = 1'b0;
	reg  [7:0] sfr_addr_i = 8'h00;
	reg        sfr_wr_i = 1'b0;
	reg  [7:0] sfr_wdata_i = 8'h00;
	reg        cmp0_i = 1'b0;
	reg        cmp1_i = 1'b0;
	reg        slow_osc_i = 1'b0;
	reg        ext_osc_i = 1'b0;
	reg  [1:0] capture_select_i = 2'b01;
	reg  [1:0] timer_int_en_i = 2'b11;
	reg        legacy_one_counter_mode_i = 1'b0;
	reg        legacy_one_pin_tick_i = 1'b0;
	wire [7:0] sfr_rdata_o;
	wire [1:0] timer_irq_o;
	wire       legacy_zero_tick_o;
	wire       legacy_one_tick_o;
	integer    err_total = 0;
	integer    total_checks = 0;
	integer    cycles = 0;
	reg  [7:0] v;
	// clock at 100 MHz
	always #5 core_clk_i = ~core_clk_i;
	// oscillator pins and capture selects are driven by t_osc
	rct_top u_dut (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
		.cmp0_i(cmp0_i), .cmp1_i(cmp1_i), .slow_osc_i(slow_osc_i), .ext_osc_i(ext_osc_i),
		.capture_select_i(capture_select_i), .timer_int_en_i(timer_int_en_i),
		.legacy_one_counter_mode_i(legacy_one_counter_mode_i),
		.legacy_one_pin_tick_i(legacy_one_pin_tick_i), .timer_irq_o(timer_irq_o),
		.legacy_zero_tick_o(legacy_zero_tick_o), .legacy_one_tick_o(legacy_one_tick_o));
	// ****
	// helpers
	// ****
	task close_out;
		begin
			$display("checks %0d errors %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// strobe stays up across back-to-back writes
	task wr(input [7:0] a, input [7:0] d);
		begin
			sfr_addr_i = a;
			sfr_wdata_i = d;
			sfr_wr_i = 1'b1;
			@(posedge core_clk_i);
			#1;
		end
	endtask
	task cyc(input integer n);
		begin
			sfr_wr_i = 1'b0;
			repeat (n) @(posedge core_clk_i);
			#1;
		end
	endtask
	// read data lands one edge after the address
	task rd(input [7:0] a);
		begin
			sfr_wr_i = 1'b0;
			sfr_addr_i = a;
			@(posedge core_clk_i);
			#1;
			v = sfr_rdata_o;
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			rd(a);
			chk(v, e);
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_regs;
		begin
			rc(8'h8E, 8'h00);
			rc(8'hC8, 8'h00);
			wr(8'h8E, 8'hAD);
			wr(8'h01, 8'hFF);
			rc(8'h8E, 8'hAD);
			rc(8'h01, 8'h00);
		end
	endtask
	// low half on system clock drives all 16 bits
	task t_full;
		begin
			wr(8'h8E, 8'h10);
			wr(8'hCC, 8'hF0);
			wr(8'hCD, 8'hFE);
			wr(8'hCA, 8'h00);
			wr(8'hCB, 8'h12);
			wr(8'hC8, 8'h04);
			cyc(20);
			chk(timer_irq_o[0], 1'b0);
			rc(8'hC8, 8'h44);
			cyc(270);
			chk(timer_irq_o[0], 1'b1);
			// a dropped enable must hide the pending flag
			timer_int_en_i = 2'b10;
			cyc(2);
			chk(timer_irq_o[0], 1'b0);
			timer_int_en_i = 2'b11;
			rc(8'hC8, 8'hC4);
			wr(8'hC8, 8'h00);
			rc(8'hCD, 8'h12);
			chk(timer_irq_o[0], 1'b0);
			// low byte rollover interrupts once the low enable is set
			wr(8'hCC, 8'hF8);
			wr(8'hC8, 8'h24);
			cyc(4);
			chk(timer_irq_o[0], 1'b0);
			cyc(10);
			chk(timer_irq_o[0], 1'b1);
			wr(8'hC8, 8'h00);
		end
	endtask
	// high half held by run bit while low reloads
	task t_split;
		begin
			wr(8'h8E, 8'h30);
			wr(8'hCA, 8'hF0);
			wr(8'hCB, 8'hC0);
			wr(8'hCC, 8'hF0);
			wr(8'hCD, 8'hC0);
			wr(8'hC8, 8'h28);
			cyc(20);
			chk(timer_irq_o[0], 1'b1);
			rc(8'hC8, 8'h68);
			rc(8'hCD, 8'hC0);
			rd(8'hCC);
			chk(v[7:4], 4'hF);
			wr(8'hC8, 8'h0C);
			cyc(30);
			chk(timer_irq_o[0], 1'b0);
			cyc(40);
			chk(timer_irq_o[0], 1'b1);
			rc(8'hC8, 8'hCC);
			rd(8'hCD);
			chk(v[7:4], 4'hC);
			wr(8'hC8, 8'h00);
		end
	endtask
	// rising edge must not capture, falling edge must
	task t_cap(input [7:0] ca, input [7:0] ra, input idx);
		begin
			wr(8'h8E, 8'h50);
			wr(ra + 8'h2, 8'h00);
			wr(ra + 8'h3, 8'h00);
			wr(ca, 8'h14);
			cyc(5);
			if (idx) cmp1_i = 1'b1; else cmp0_i = 1'b1;
			cyc(10);
			rc(ca, 8'h14);
			if (idx) cmp1_i = 1'b0; else cmp0_i = 1'b0;
			cyc(10);
			chk(timer_irq_o[idx], 1'b1);
			rc(ca, 8'h94);
			rd(ra);
			chk(v > 8'd10 && v < 8'd60, 1'b1);
			rc(ra + 8'h1, 8'h00);
			wr(ca, 8'h00);
		end
	endtask
	// oscillator pins through both divide-by-8 paths
	task t_osc;
		integer i, n;
		begin
			capture_select_i = 2'b11;
			wr(8'h8E, 8'h03);
			wr(8'hCC, 8'h00);
			wr(8'hCD, 8'h00);
			wr(8'h94, 8'h00);
			wr(8'h95, 8'h00);
			wr(8'hC8, 8'h06);
			wr(8'h91, 8'h15);
			n = 0;
			// 32 rising edges, high four cycles so the filter keeps them
			for (i = 0; i < 272; i = i + 1) begin
				slow_osc_i = i[2] & (i < 256);
				ext_osc_i = i[2] & (i < 256);
				cyc(1);
				n = n + legacy_zero_tick_o;
			end
			chk(n[15:0], 16'd4);
			rc(8'hCC, 8'h04);
			rc(8'h94, 8'h04);
			rc(8'h92, 8'h03);
			rc(8'h91, 8'h95);
			chk(timer_irq_o[1], 1'b1);
			wr(8'h91, 8'h00);
			wr(8'hC8, 8'h00);
			capture_select_i = 2'b01;
		end
	endtask
	task t_leg;
		integer p, n, i;
		begin
			for (p = 0; p < 3; p = p + 1) begin
				wr(8'h8E, p[7:0]);
				cyc(2);
				n = 0;
				for (i = 0; i < 96; i = i + 1) begin
					cyc(1);
					n = n + legacy_zero_tick_o;
				end
				chk(n[15:0], p == 0 ? 16'd8 : p == 1 ? 16'd24 : 16'd2);
			end
			wr(8'h8E, 8'h08);
			legacy_one_counter_mode_i = 1'b1;
			n = 0;
			for (i = 0; i < 20; i = i + 1) begin
				legacy_one_pin_tick_i = i[0] & (i < 10);
				cyc(1);
				n = n + legacy_one_tick_o;
			end
			chk(n[15:0], 16'd5);
			legacy_one_counter_mode_i = 1'b0;
		end
	endtask
	// hang guard, run needs about 1100 cycles
	always @(posedge core_clk_i) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			close_out;
		end
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		#1;
		resetn_i = 1'b1;
		t_regs;
		t_full;
		t_split;
		t_cap(8'hC8, 8'hCA, 1'b0);
		t_cap(8'h91, 8'h92, 1'b1);
		t_osc;
		t_leg;
		close_out;
	end
endmodule
